// [verilog/cmc_clock_core.sv]
// cmc_clock_core: cpu clock mode, pll model, i/o prescaler, emi
// phase modulator and apb register slave.
// assumes clk_i at 200 MHz; crystal, system and peripheral clocks are
// one-cycle enable ticks in the clk_i domain.
`timescale 1ns/1ps

module cmc_clock_core
  import cmc_pkg::*;
(
  input  wire logic                        clk_i,       // 200 MHz clock
  input  wire logic                        srst_i,      // sync reset
  input  wire logic                        psel_i,      // apb select
  input  wire logic                        penable_i,   // apb enable
  input  wire logic                        pwrite_i,    // apb write
  input  wire logic [cmc_pkg::ADDR_W-1:0]  paddr_i,     // apb address
  input  wire logic [31:0]                 pwdata_i,    // apb wdata
  output logic      [31:0]                 prdata_o,    // apb rdata
  output logic                             pready_o,    // apb ready
  output logic                             pslverr_o,   // apb error
  input  wire logic [1:0]                  hw_co_presc_i,     // option
  input  wire logic [8:0]                  hw_co_taps_i,      // option
  input  wire logic [2:0]                  hw_co_b_tap_i,     // option
  input  wire logic                        shared_pin_clock_choice_i,
  output logic                             sys_clk_en_o,      // fsys
  output logic                             bus_clk_en_o,      // fbus
  output logic                             io_clk_en_o,       // fio
  output logic [cmc_pkg::NUM_PERIPH-1:0]   periph_clk_en_o,   // f0..f17
  output logic                             clock_output_a_o,  // co a
  output logic                             clock_output_b_o,  // co b
  output logic                             prescaled_clock_out_a_o,
  output logic                             shared_pin_o,      // pin
  output logic                             lock_indicator_output_o,
  output logic                             clkout_irq_o       // irq src
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cmc_mode_e   mode;       // requested mode
    cmc_mode_e   eff;        // mode applied to the clocks
    logic [3:0]  pmf;
    logic [3:0]  iop;
    logic [1:0]  cosel;
    logic        lock_sel;
    logic [1:0]  emi_mode;
    logic [3:0]  emi_tol;
    logic [5:0]  emi_sup;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  xcnt;
    logic [6:0]  slow_cnt;
    logic [4:0]  acc;
    logic [3:0]  io_cnt;
    logic        half;
    logic [7:0]  lock_cnt;
    logic        locked;
    logic [1:0]  sync_cnt;
    logic        pll_act;
    logic [15:0] lfsr;
    logic        pend;
    logic [2:0]  dly;
    logic [2:0]  inph_cnt;
    logic        inph;
    logic        xtal;
    logic        sys;
    logic        bus;
    logic        io;
    logic        f0;
    logic        f1;
    logic        deep;
    logic        shared;
    logic        lock_pin;
  } cmc_core_s;

  cmc_core_s st_reg, st_next;
  cmc_clk_if lnk ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_pll(input cmc_mode_e md);
    return (md == CMC_PLL) || (md == CMC_PLL_DIRECT_MODE);
  endfunction : is_pll

  function automatic logic mode_ok(input logic [2:0] code);
    return (code == CMC_SLOW) || (code == CMC_FAST) || (code == CMC_DEEP) ||
           (code == CMC_PLL) || (code == CMC_PLL_DIRECT_MODE);
  endfunction : mode_ok

  // delay never exceeds the tolerance nor the closest pulse spacing
  function automatic logic [2:0] emi_delay(input logic [1:0]  md,
                                           input logic [15:0] lf,
                                           input logic [3:0]  tol,
                                           input logic [5:0]  sup);
    logic [3:0] raw;
    logic [3:0] lim;
    raw = 4'd0;
    lim = (tol < 4'(EMI_MAX_DLY)) ? tol : 4'(EMI_MAX_DLY);
    case (md)
      2'd1:    raw = {2'b00, lf[1:0]};
      2'd2:    raw = lf[0] ? tol : 4'd0;
      2'd3:    raw = lf[3:0] ^ sup[3:0];
      default: raw = 4'd0;
    endcase
    if (raw > lim) raw = lim;
    return raw[2:0];
  endfunction : emi_delay

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [4:0]  n_val;
  logic [3:0]  m_val;
  logic [5:0]  acc_sum;
  logic        pll_pulse;
  logic        raw_sys;
  logic        mod_sys;
  logic        emi_on;
  logic        eff_pll;
  logic        hit;
  logic [31:0] rd;
  logic [2:0]  d;

  always_comb begin
    st_next   = st_reg;
    n_val     = {1'b0, st_reg.pmf} + 5'd1;
    m_val     = (st_reg.iop == 4'd0) ? 4'd1 : st_reg.iop;
    eff_pll   = is_pll(st_reg.eff);
    hit       = 1'b1;
    rd        = '0;
    d         = 3'd0;
    mod_sys   = 1'b0;

    // crystal tick and slow divider
    st_next.xtal = st_reg.xcnt == 4'(XTAL_DIV - 1);
    st_next.xcnt = st_reg.xcnt + 4'd1;
    if (st_reg.xtal) st_next.slow_cnt = st_reg.slow_cnt + 7'd1;

    // pll model: n system pulses per crystal period
    acc_sum   = {1'b0, st_reg.acc} + {1'b0, n_val};
    pll_pulse = eff_pll && (acc_sum >= 6'(XTAL_DIV));
    if (eff_pll) begin
      st_next.acc = pll_pulse ? 5'(acc_sum - 6'(XTAL_DIV)) : acc_sum[4:0];
    end else begin
      st_next.acc = 5'd0;
    end
    raw_sys = eff_pll ? pll_pulse : st_reg.xtal;

    // lock model: pll runs only while the multiplier is nonzero
    if (st_reg.pmf == 4'd0) begin
      st_next.lock_cnt = 8'd0;
      st_next.locked   = 1'b0;
    end else if (st_reg.lock_cnt == 8'(LOCK_CYC)) begin
      st_next.locked   = 1'b1;
    end else begin
      st_next.lock_cnt = st_reg.lock_cnt + 8'd1;
    end

    // apply mode on a crystal boundary only, so no runt pulses
    if (st_reg.xtal) begin
      if (is_pll(st_reg.mode)) begin
        if (st_reg.sync_cnt == 2'(SYNC_TICKS)) begin
          st_next.eff = st_reg.mode;
        end else begin
          st_next.sync_cnt = st_reg.sync_cnt + 2'd1;
          st_next.eff      = CMC_FAST;
        end
      end else begin
        st_next.sync_cnt = 2'd0;
        st_next.eff      = st_reg.mode;
      end
    end
    st_next.pll_act = is_pll(st_next.eff);

    // emi modulator: delays each system pulse, never drops one
    emi_on = eff_pll && (st_reg.emi_mode != 2'd0) &&
             (n_val <= 5'(EMI_MAX_N));
    if (raw_sys) st_next.lfsr = {st_reg.lfsr[14:0],
      st_reg.lfsr[15] ^ st_reg.lfsr[13] ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};
    if (st_reg.pend) begin
      if (st_reg.dly <= 3'd1) begin
        mod_sys      = 1'b1;
        st_next.pend = 1'b0;
      end
      st_next.dly = st_reg.dly - 3'd1;
    end
    if (raw_sys) begin
      d = emi_on ? emi_delay(st_reg.emi_mode, st_reg.lfsr,
                             st_reg.emi_tol, st_reg.emi_sup) : 3'd0;
      if (d == 3'd0) begin
        mod_sys = 1'b1;
      end else begin
        st_next.pend = 1'b1;
        st_next.dly  = d;
      end
      if (d == 3'd0 && !st_reg.pend) begin
        if (st_reg.inph_cnt != 3'(INPH_PULSES))
          st_next.inph_cnt = st_reg.inph_cnt + 3'd1;
      end else begin
        st_next.inph_cnt = 3'd0;
      end
    end
    st_next.inph = st_reg.inph_cnt == 3'(INPH_PULSES);

    // clock rates per mode; derived clocks follow mod_sys, except bus and io in slow and deep, which come from the slow divider
    st_next.deep = st_reg.eff == CMC_DEEP;
    st_next.sys  = mod_sys;
    case (st_reg.eff)
      CMC_SLOW, CMC_DEEP: begin
        st_next.bus = st_reg.xtal && (st_reg.slow_cnt == 7'(SLOW_DIV - 1));
        st_next.io  = st_next.bus;
        st_next.f0  = st_reg.xtal;
        st_next.f1  = st_reg.xtal;
      end
      CMC_PLL: begin
        st_next.bus = mod_sys;
        st_next.io  = mod_sys && (st_reg.io_cnt >= m_val - 4'd1);
        st_next.f0  = st_next.io;
        st_next.f1  = st_next.io && st_reg.half;
      end
      CMC_PLL_DIRECT_MODE: begin
        st_next.bus = mod_sys;
        st_next.io  = mod_sys && (st_reg.io_cnt >= m_val - 4'd1);
        st_next.f0  = st_next.io;
        st_next.f1  = st_next.io;
      end
      default: begin
        st_next.bus = st_reg.xtal;
        st_next.io  = st_reg.xtal;
        st_next.f0  = st_reg.xtal;
        st_next.f1  = st_reg.xtal;
      end
    endcase
    if (!eff_pll) st_next.io_cnt = 4'd0;
    else if (st_next.io) st_next.io_cnt = 4'd0;
    else if (mod_sys) st_next.io_cnt = st_reg.io_cnt + 4'd1;
    if (!eff_pll) st_next.half = 1'b0;
    else if (st_next.io) st_next.half = !st_reg.half;

    // pins
    st_next.lock_pin = st_reg.lock_sel && st_reg.locked;
    st_next.shared   = shared_pin_clock_choice_i ? lnk.co_b
                                                 : lnk.co_pre;

    // apb: access phase gets pready one cycle after it begins
    case (paddr_i)
      ADDR_MODE:  rd[2:0] = st_reg.mode;
      ADDR_PLL: begin
        rd[3:0]          = st_reg.pmf;
        rd[PLL_LCK_BIT]  = st_reg.locked;
        rd[PLL_ACT_BIT]  = st_reg.pll_act;
      end
      ADDR_IOP:   rd[3:0] = st_reg.iop;
      ADDR_COSEL: rd[1:0] = st_reg.cosel;
      ADDR_LOCKO: rd[0]   = st_reg.lock_sel;
      ADDR_EMI: begin
        rd[1:0]                       = st_reg.emi_mode;
        rd[EMI_TOL_LSB +: 4]          = st_reg.emi_tol;
        rd[EMI_SUP_LSB +: 6]          = st_reg.emi_sup;
        rd[EMI_INPH_BIT]              = st_reg.inph;
      end
      default:    hit = 1'b0;
    endcase
    if (psel_i && penable_i && st_reg.pready) begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata  = '0;
      if (pwrite_i && hit) begin
        case (paddr_i)
          ADDR_MODE: begin
            if (mode_ok(pwdata_i[2:0]))
              st_next.mode = cmc_mode_e'(pwdata_i[2:0]);
          end
          ADDR_PLL:   st_next.pmf = pwdata_i[3:0];
          ADDR_IOP:   st_next.iop = pwdata_i[3:0];
          ADDR_COSEL: st_next.cosel = pwdata_i[1:0];
          ADDR_LOCKO: st_next.lock_sel = pwdata_i[0];
          ADDR_EMI: begin
            st_next.emi_mode = pwdata_i[1:0];
            st_next.emi_tol  = pwdata_i[EMI_TOL_LSB +: 4];
            st_next.emi_sup  = pwdata_i[EMI_SUP_LSB +: 6];
          end
          default: st_next.pslverr = 1'b0;
        endcase
        if (paddr_i == ADDR_PLL && pwdata_i[3:0] != st_reg.pmf) begin
          st_next.lock_cnt = 8'd0;
          st_next.locked   = 1'b0;
        end
      end
    end else if (psel_i && penable_i) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = !hit;
      st_next.prdata  = pwrite_i ? 32'h0000_0000 : rd;
    end else begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata  = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg      <= '0;
      st_reg.mode <= MODE_RST;
      st_reg.eff  <= MODE_RST;
      st_reg.lfsr <= LFSR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // submodules and outputs
  // ----------------------------------------------------------------
  assign lnk.xtal_tick = st_reg.xtal;
  assign lnk.f0_tick   = st_reg.f0;
  assign lnk.f1_tick   = st_reg.f1;
  assign lnk.low_mask  = st_reg.deep;
  assign lnk.presc     = hw_co_presc_i;
  assign lnk.sel       = st_reg.cosel;
  assign lnk.taps      = hw_co_taps_i;
  assign lnk.b_tap     = hw_co_b_tap_i;

  cmc_div_chain u_chain (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .lnk    (lnk.chain)
  );

  cmc_clkout u_cout (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .lnk    (lnk.cout)
  );

  assign prdata_o                = st_reg.prdata;
  assign pready_o                = st_reg.pready;
  assign pslverr_o               = st_reg.pslverr;
  assign sys_clk_en_o            = st_reg.sys;
  assign bus_clk_en_o            = st_reg.bus;
  assign io_clk_en_o             = st_reg.io;
  assign periph_clk_en_o         = lnk.periph;
  assign clock_output_a_o        = lnk.co_a;
  assign clock_output_b_o        = lnk.co_b;
  assign prescaled_clock_out_a_o = lnk.co_pre;
  assign clkout_irq_o            = lnk.co_irq;
  assign shared_pin_o            = st_reg.shared;
  assign lock_indicator_output_o = st_reg.lock_pin;

endmodule : cmc_clock_core

// [verilog/cmc_pkg.sv]
// cmc_pkg: constants and types shared by the clock/mode controller.
// assumes a single 200 MHz clock; the crystal is a derived tick.
package cmc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int XTAL_DIV      = 16;   // clk cycles per crystal period
  localparam int SLOW_DIV      = 128;
  localparam int LOCK_TIME_NS  = 1000; // modelled pll settle time
  localparam int LOCK_CYC      = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_TICKS    = 2;    // crystal ticks to sync dividers
  localparam int EMI_MAX_MHZ   = 48;
  localparam int EMI_MAX_N     = (EMI_MAX_MHZ * XTAL_DIV) / CLK_MHZ;
  localparam int EMI_MAX_DLY   = 4;    // below the closest fsys spacing
  localparam int INPH_PULSES   = 7;
  localparam int NUM_PERIPH    = 18;
  localparam int DEEP_STOPPED  = 5;    // f0..f4 held at zero

  // ----------------------------------------------------------------
  // clock output prescaler, in clk cycles
  // ----------------------------------------------------------------
  localparam logic [5:0] PRE_P10 = 6'd16;
  localparam logic [5:0] PRE_H10 = 6'd8;
  localparam logic [5:0] PRE_P15 = 6'd24;  // 33 percent duty
  localparam logic [5:0] PRE_H15 = 6'd8;
  localparam logic [5:0] PRE_P20 = 6'd32;
  localparam logic [5:0] PRE_H20 = 6'd16;
  localparam logic [5:0] PRE_P25 = 6'd40;  // 20 percent duty
  localparam logic [5:0] PRE_H25 = 6'd8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_PLL    = 8'h04;
  localparam logic [7:0] ADDR_IOP    = 8'h08;
  localparam logic [7:0] ADDR_COSEL  = 8'h0C;
  localparam logic [7:0] ADDR_LOCKO  = 8'h10;
  localparam logic [7:0] ADDR_EMI    = 8'h14;
  localparam int PLL_LCK_BIT  = 6;
  localparam int PLL_ACT_BIT  = 7;
  localparam int EMI_TOL_LSB  = 4;
  localparam int EMI_SUP_LSB  = 8;
  localparam int EMI_INPH_BIT = 16;
  localparam logic [15:0] LFSR_RST = 16'hACE1;

  typedef enum logic [2:0] {
    CMC_SLOW = 3'b000,
    CMC_FAST = 3'b001,
    CMC_DEEP = 3'b010,
    CMC_PLL  = 3'b011,
    CMC_PLL_DIRECT_MODE = 3'b111
  } cmc_mode_e;

  localparam cmc_mode_e MODE_RST = CMC_FAST;

endpackage : cmc_pkg

// [verilog/cmc_clk_if.sv]
// cmc_clk_if: ticks and clock-output signals between the core and
// its divider chain and clock-output unit; one clock domain.
`timescale 1ns/1ps
interface cmc_clk_if;
  logic        f0_tick;
  logic        f1_tick;
  logic        low_mask;
  logic        xtal_tick;
  logic [17:0] periph;
  logic [1:0]  presc;
  logic [1:0]  sel;
  logic [8:0]  taps;
  logic [2:0]  b_tap;
  logic        co_a;
  logic        co_b;
  logic        co_pre;
  logic        co_irq;

  modport core  (output f0_tick, f1_tick, low_mask, xtal_tick, presc, sel,
                 taps, b_tap, input periph, co_a, co_b, co_pre, co_irq);
  modport chain (input f0_tick, f1_tick, low_mask, output periph);
  modport cout  (input xtal_tick, presc, sel, taps, b_tap,
                 output co_a, co_b, co_pre, co_irq);
endinterface : cmc_clk_if

// [verilog/cmc_div_chain.sv]
// cmc_div_chain: halving chain producing peripheral clock ticks.
// assumes f0/f1 ticks are one-cycle pulses from the core.
`timescale 1ns/1ps
module cmc_div_chain
  import cmc_pkg::*;
(
  input  wire logic clk_i,   // system clock
  input  wire logic srst_i,  // sync reset
  cmc_clk_if.chain  lnk      // ticks in, peripheral ticks out
);
  typedef struct packed {
    logic [16:0] cnt;
    logic [17:0] periph;
  } cmc_chain_s;

  cmc_chain_s st_reg, st_next;

  function automatic logic low_ones(input logic [16:0] v, input int len);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 17; i++) begin
      if (i < len) r = r & v[i];
    end
    return r;
  endfunction : low_ones

  always_comb begin
    st_next = st_reg;
    if (lnk.f1_tick) st_next.cnt = st_reg.cnt + 17'd1;
    st_next.periph[0] = lnk.f0_tick;
    st_next.periph[1] = lnk.f1_tick;
    for (int k = 2; k < NUM_PERIPH; k++) begin
      st_next.periph[k] = lnk.f1_tick & low_ones(st_reg.cnt, k - 1);
    end
    for (int k = 0; k < DEEP_STOPPED; k++) begin
      if (lnk.low_mask) st_next.periph[k] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign lnk.periph = st_reg.periph;
endmodule : cmc_div_chain

// [verilog/cmc_clkout.sv]
// cmc_clkout: clock-output prescaler and 4-to-1 output multiplexer.
// assumes a crystal tick input; runs regardless of the cpu mode.
`timescale 1ns/1ps
module cmc_clkout
  import cmc_pkg::*;
(
  input  wire logic clk_i,   // system clock
  input  wire logic srst_i,  // sync reset
  cmc_clk_if.cout   lnk      // options in, clock outputs out
);
  typedef struct packed {
    logic [5:0] pcnt;
    logic [7:0] xcnt;
    logic       pre;
    logic       irq;
    logic       co_a;
    logic       co_b;
  } cmc_cout_s;

  cmc_cout_s  st_reg, st_next;
  logic [5:0] period;
  logic [5:0] high;
  logic [2:0] tap_idx;

  always_comb begin
    // fixed by option pins, not by the select register
    case (lnk.presc)
      2'd0:    begin period = PRE_P10; high = PRE_H10; end
      2'd1:    begin period = PRE_P15; high = PRE_H15; end
      2'd2:    begin period = PRE_P20; high = PRE_H20; end
      2'd3:    begin period = PRE_P25; high = PRE_H25; end
      default: begin period = PRE_P10; high = PRE_H10; end
    endcase
    st_next = st_reg;
    // counts raw clk, so slow modes never touch it
    st_next.pcnt = (st_reg.pcnt >= period - 6'd1) ? 6'd0
                                                  : st_reg.pcnt + 6'd1;
    if (lnk.xtal_tick) st_next.xcnt = st_reg.xcnt + 8'd1;
    st_next.pre = st_reg.pcnt < high;
    st_next.irq = st_reg.pcnt == 6'd0;
    case (lnk.sel)
      2'd1:    tap_idx = lnk.taps[2:0];
      2'd2:    tap_idx = lnk.taps[5:3];
      2'd3:    tap_idx = lnk.taps[8:6];
      default: tap_idx = 3'd0;
    endcase
    st_next.co_a = (lnk.sel == 2'd0) ? st_reg.pre
                                     : st_reg.xcnt[tap_idx];
    st_next.co_b = st_reg.xcnt[lnk.b_tap];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign lnk.co_pre = st_reg.pre;
  assign lnk.co_irq = st_reg.irq;
  assign lnk.co_a   = st_reg.co_a;
  assign lnk.co_b   = st_reg.co_b;
endmodule : cmc_clkout

// [sim/cmc_clock_core_chk.sv]
// cmc_clock_core_chk: bus handshake and clock-output checks.
// assumes it is bound to cmc_clock_core and sees only its ports.
`timescale 1ns/1ps
module cmc_clock_core_chk (
  input wire logic        clk_i,                   // clock
  input wire logic        srst_i,                  // sync reset
  input wire logic        psel_i,                  // apb select
  input wire logic        penable_i,               // apb enable
  input wire logic        pready_o,                // apb ready
  input wire logic        pslverr_o,               // apb error
  input wire logic [31:0] prdata_o,                // apb rdata
  input wire logic [1:0]  hw_co_presc_i,           // prescaler option
  input wire logic        prescaled_clock_out_a_o, // prescaled out
  input wire logic        clkout_irq_o             // irq source
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // first access cycle of a transfer
  sequence s_access;
    psel_i && penable_i && !$past(penable_i);
  endsequence
  // a 1/1.5 pulse is 8 clk high out of 24
  sequence s_high8;
    prescaled_clock_out_a_o [*8] ##1 !prescaled_clock_out_a_o;
  endsequence
  apb_answer_a: assert property (s_access |=> pready_o)
    else $error("ready late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  err_data_a: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("data on error");
  irq_pulse_a: assert property (clkout_irq_o |=> !clkout_irq_o)
    else $error("irq too long");
  irq_period_a: assert property (
    clkout_irq_o && hw_co_presc_i == 2'h0 && $stable(hw_co_presc_i)
    |-> ##16 clkout_irq_o) else $error("irq period");
  duty_third_a: assert property (
    $rose(prescaled_clock_out_a_o) && hw_co_presc_i == 2'h1 |-> s_high8)
    else $error("duty wrong");
endmodule : cmc_clock_core_chk
bind cmc_clock_core cmc_clock_core_chk cmc_clock_core_chk_i (.clk_i,
  .srst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .prdata_o,
  .hw_co_presc_i, .prescaled_clock_out_a_o, .clkout_irq_o);

// [sim/cmc_consumer.sv]
// cmc_consumer: stand-in for cpu, peripherals and pins; counts rising
// edges, so one-cycle enables and square clock levels both count.
// assumes one clock domain; clr_i restarts the window.
`timescale 1ns/1ps
module cmc_consumer (
  input  wire logic        clk_i,     // clock
  input  wire logic        clr_i,     // restart count
  input  wire logic [8:0]  en_i,      // sys bus io f0 f1 f4 coa cob pin
  output logic      [15:0] cnt_o [9]  // rising edges seen
);
  logic [8:0] prev;
  always_ff @(posedge clk_i) begin
    prev <= en_i;
    for (int k = 0; k < 9; k++) begin
      cnt_o[k] <= clr_i ? 16'h0000 : cnt_o[k] + 16'(en_i[k] & !prev[k]);
    end
  end
endmodule : cmc_consumer

// [sim/cpu_clock_mode_system_bench.sv]
// cpu_clock_mode_system_bench: directed test of the clock controller.
// assumes cmc_clock_core, cmc_consumer and the bound checker.
`timescale 1ns/1ps
module cpu_clock_mode_system_bench;
  import cmc_pkg::*;
  logic        clk_i, srst_i, psel, pen, pwr, choice, clr;
  logic        pready, perr, lock_o, sys_en, bus_en, io_en;
  logic        co_a, co_b, shp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  presc;
  logic [17:0] periph;
  logic [15:0] cnt [9];
  int          n_fail = 0;
  int          n_tests = 0;
  cmc_clock_core cmc_clock_core_i (.clk_i, .srst_i, .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .hw_co_presc_i(presc), .hw_co_taps_i(9'h0d1), .hw_co_b_tap_i(3'h2),
    .shared_pin_clock_choice_i(choice), .sys_clk_en_o(sys_en),
    .bus_clk_en_o(bus_en), .io_clk_en_o(io_en), .periph_clk_en_o(periph),
    .clock_output_a_o(co_a), .clock_output_b_o(co_b),
    .prescaled_clock_out_a_o(), .shared_pin_o(shp),
    .lock_indicator_output_o(lock_o), .clkout_irq_o());
  cmc_consumer cmc_consumer_i (.clk_i, .clr_i(clr), .cnt_o(cnt),
    .en_i({shp, co_b, co_a, periph[4], periph[1:0], io_en, bus_en,
           sys_en}));
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    psel   <= 1'h1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'h1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk_i);
    end while (pready !== 1'h1);
    r = perr ? 32'hdead_0000 : prdata;
    psel <= 1'h0;
    pen  <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e,
                       input string nm);
    logic [31:0] r;
    apb(1'h0, a, 32'h0, r);
    chk(nm, e, r & m);
  endtask : rdchk
  // rising edges over 2048 clk; a negative entry is not checked
  task automatic rates(input int e [9]);
    clr <= 1'h1;
    @(posedge clk_i);
    clr <= 1'h0;
    repeat (2048) @(posedge clk_i);
    #1;
    for (int k = 0; k < 9; k++) begin
      if (e[k] >= 0) chk($sformatf("rate %0d", k), 32'(e[k]), 32'(cnt[k]));
    end
  endtask : rates
  task automatic mode(input logic [2:0] m);
    wr(ADDR_MODE, {29'h0, m});
    repeat (64) @(posedge clk_i);
  endtask : mode
  task automatic waitact(input logic v);
    logic [31:0] r;
    int n = 0;
    do begin
      apb(1'h0, ADDR_PLL, 32'h0, r);
      n++;
    end while (r[PLL_ACT_BIT] !== v && n < 40);
    chk("pll active", {31'h0, v}, {31'h0, r[PLL_ACT_BIT]});
  endtask : waitact
  task automatic t_regs;
    rdchk(ADDR_MODE, 32'h7, 32'h1, "mode");
    rdchk(ADDR_PLL, 32'hff, 32'h0, "pll");
    rdchk(ADDR_EMI, 32'h3, 32'h0, "emi");
    rdchk(8'h18, 32'hffff_ffff, 32'hdead_0000, "unmapped");
  endtask : t_regs
  task automatic t_slow;
    rates('{128, 128, 128, 128, 128, -1, 128, 16, 128});
    wr(ADDR_COSEL, 32'h1);
    mode(3'h0);
    rates('{-1, 1, 1, 128, 128, -1, 32, 16, 128});
    mode(3'h2);
    rates('{-1, 1, 1, 0, 0, 0, 32, 16, 128});
    mode(3'h4);
    rdchk(ADDR_MODE, 32'h7, 32'h2, "refused");
    mode(3'h1);
  endtask : t_slow
  task automatic t_pll;
    wr(ADDR_PLL, 32'h3);
    wr(ADDR_IOP, 32'h2);
    repeat (250) @(posedge clk_i);
    rdchk(ADDR_PLL, 32'h4f, 32'h43, "lock");
    wr(ADDR_LOCKO, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("lock pin", 32'h1, {31'h0, lock_o});
    mode(3'h3);
    waitact(1'h1);
    rates('{512, 512, 256, 256, 128, 16, 32, 16, 128});
    mode(3'h1);
    waitact(1'h0);
    mode(3'h7);
    waitact(1'h1);
    rates('{512, 512, 256, 256, 256, 32, 32, 16, 128});
    mode(3'h1);
    waitact(1'h0);
  endtask : t_pll
  // duty of the 1/1.5 prescaler is judged by the bound checker
  task automatic t_duty;
    presc  <= 2'h1;
    srst_i <= 1'h1;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'h0;
    choice <= 1'h1;
    repeat (400) @(posedge clk_i);
    rates('{128, 128, 128, 128, 128, 16, -1, 16, 16});
    rdchk(ADDR_PLL, 32'hff, 32'h0, "pll reset");
  endtask : t_duty
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {srst_i, psel, pen, pwr, choice, clr} = 6'h20;
    paddr  = 8'h00;
    pwdata = 32'h0;
    presc  = 2'h0;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'h0;
    t_regs();
    t_slow();
    t_pll();
    t_duty();
    report_and_stop();
  end
endmodule : cpu_clock_mode_system_bench
